// file: src/pcr_pad_regs.v
// Summary of operation
// RULE1 - A set output disable bit forces the pad driver off whatever a peripheral requests.
// RULE2 - The two-bit drive field selects 2, 4, 8 or 12 mA for codes 0 to 3.
// RULE3 - One bank-wide voltage bit picks 3.3 V at zero or 1.8 V at one, and resets to zero.
// RULE4 - Bit zero of each pad register picks fast edges at one, slow at zero, reset slow.
// RULE5 - The bank decodes from its own base, voltage select at 0 and pads at words 0x4 to 0x18.
// RULE6 - Input, pull-up, pull-down and Schmitt bits are plain storage; reserved bits read zero.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.vh"

module pcr_pad_regs #(
  parameter NUM_PADS = 7,
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NUM_PADS-1:0] periphOe,
  output wire [NUM_PADS-1:0] padOe,
  output wire [NUM_PADS-1:0] inputEnableBit,
  output wire [2*NUM_PADS-1:0] driveSel,
  output wire [NUM_PADS-1:0] pullUpEn,
  output wire [NUM_PADS-1:0] pullDownEn,
  output wire [NUM_PADS-1:0] schmittEn,
  output wire [NUM_PADS-1:0] fastEdgeSel,
  output reg voltageSel
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode. Pads 0..5 are the flash bank, pad 6 the debug data pad.
  // Map of the window, one 32-bit word per register:
  //   0x000 bank voltage select, bit 0 only.
  //   0x004 flash clock pad.
  //   0x008 to 0x014 flash data pads 0 to 3.
  //   0x018 flash select pad.
  //   0x080 debug data pad.
  // Every other offset is unmapped: reads return zero and the error flag is raised.

  localparam [ADDR_W-1:0] ADDR_VSEL = `PCR_OFF_VSEL;
  localparam [ADDR_W-1:0] ADDR_CLK = `PCR_OFF_CLK;
  localparam [ADDR_W-1:0] ADDR_D0 = `PCR_OFF_D0;
  localparam [ADDR_W-1:0] ADDR_D1 = `PCR_OFF_D1;
  localparam [ADDR_W-1:0] ADDR_D2 = `PCR_OFF_D2;
  localparam [ADDR_W-1:0] ADDR_D3 = `PCR_OFF_D3;
  localparam [ADDR_W-1:0] ADDR_SEL = `PCR_OFF_SEL;
  localparam [ADDR_W-1:0] ADDR_DBG = `PCR_OFF_DBG;

  wire accessPhase = psel & penable;
  reg hitVsel;
  reg hitPad;
  reg [2:0] padIdx;

  // Exact compares only, so a misaligned offset never aliases onto a pad.
  always @* begin
    hitVsel = 1'b0;
    hitPad = 1'b0;
    padIdx = 3'h0;
    if (paddr == ADDR_VSEL) begin // [RULE5]
      hitVsel = 1'b1;
    end else if (paddr == ADDR_CLK) begin // [RULE5]
      hitPad = 1'b1;
      padIdx = 3'h0;
    end else if (paddr == ADDR_D0) begin // [RULE5]
      hitPad = 1'b1;
      padIdx = 3'h1;
    end else if (paddr == ADDR_D1) begin // [RULE5]
      hitPad = 1'b1;
      padIdx = 3'h2;
    end else if (paddr == ADDR_D2) begin // [RULE5]
      hitPad = 1'b1;
      padIdx = 3'h3;
    end else if (paddr == ADDR_D3) begin // [RULE5]
      hitPad = 1'b1;
      padIdx = 3'h4;
    end else if (paddr == ADDR_SEL) begin // [RULE5]
      hitPad = 1'b1;
      padIdx = 3'h5;
    end else if (paddr == ADDR_DBG) begin
      hitPad = 1'b1;
      padIdx = 3'h6;
    end
  end

  wire hit = hitVsel | hitPad;
  // The first access cycle is the one without pready; the answer follows
  // one cycle later, so each access has one wait state. Gating on ~pready
  // makes the write land exactly once even though the request is still
  // held during the answer cycle.
  wire takenCycle = accessPhase & ~pready;
  // Only byte lane 0 carries fields; a write without it is dropped silently.
  wire doWrite = takenCycle & pwrite & hit & pstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  // Pad registers.

  wire [8*NUM_PADS-1:0] padRegs;

  genvar g;
  generate
    for (g = 0; g < NUM_PADS; g = g + 1) begin : gPad
      localparam [7:0] RST = (g == 0) ? `PCR_RST_CLK :
                             (g == 5) ? `PCR_RST_SEL :
                             (g == 6) ? `PCR_RST_DBG : `PCR_RST_DATA;
      pcr_pad_ctrl #(
        .RESET_VALUE(RST)
      ) uPad (
        .clk(clk),
        .reset_n(reset_n),
        .writeEn(doWrite & hitPad & (padIdx == g)),
        .writeData(pwdata[7:0]),
        .periphOe(periphOe[g]),
        .padReg(padRegs[8*g +: 8]),
        .padOe(padOe[g]),
        .inputEnableBit(inputEnableBit[g]),
        .driveSel(driveSel[2*g +: 2]),
        .pullUpEn(pullUpEn[g]),
        .pullDownEn(pullDownEn[g]),
        .schmittEn(schmittEn[g]),
        .fastEdgeSel(fastEdgeSel[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Voltage select and bus answer.

  reg [31:0] readNext;

  always @* begin
    readNext = 32'h00000000;
    if (hitVsel) begin
      readNext = {31'h00000000, voltageSel}; // [RULE6]
    end else if (hitPad) begin
      readNext = {24'h000000, padRegs[8*padIdx +: 8]}; // [RULE6]
    end
  end

  // The bank voltage bit is the only control field stored outside the pad instances.
  // It applies to the whole flash bank, so it has no per-pad copy.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      voltageSel <= `PCR_RST_VSEL; // [RULE3]
    end else if (doWrite & hitVsel) begin
      voltageSel <= pwdata[0]; // [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer. All three outputs are registered pulses that stand for the
  // single cycle in which pready is high; read data is zero otherwise so a
  // stale value can never be mistaken for a fresh one.

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= takenCycle;
      pslverr <= takenCycle & ~hit; // [RULE5]
      prdata <= (takenCycle & ~pwrite) ? readNext : 32'h00000000;
    end
  end

endmodule // pcr_pad_regs

`default_nettype wire

// file: pkg/pcr_defs.vh
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

// Register byte offsets within the flash pad bank window.
`define PCR_OFF_VSEL 12'h000
`define PCR_OFF_CLK 12'h004
`define PCR_OFF_D0 12'h008
`define PCR_OFF_D1 12'h00C
`define PCR_OFF_D2 12'h010
`define PCR_OFF_D3 12'h014
`define PCR_OFF_SEL 12'h018
`define PCR_OFF_DBG 12'h080
`define PCR_BANK_BASE 32'h40020000

// Pad register field positions.
`define PCR_BIT_OD 7
`define PCR_BIT_IE 6
`define PCR_DRV_HI 5
`define PCR_DRV_LO 4
`define PCR_BIT_PU 3
`define PCR_BIT_PD 2
`define PCR_BIT_SCH 1
`define PCR_BIT_FAST 0
`define PCR_PAD_W 8

// Reset values of the voltage select and pad registers.
`define PCR_RST_VSEL 1'h0
`define PCR_RST_CLK 8'h56
`define PCR_RST_DATA 8'h52
`define PCR_RST_SEL 8'h5A
`define PCR_RST_DBG 8'h5A

`endif

// file: src/pcr_pad_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.vh"

// One pad's control register and the pad-facing levels it produces.
module pcr_pad_ctrl #(
  parameter [7:0] RESET_VALUE = 8'h52
) (
  input wire clk,
  input wire reset_n,
  input wire writeEn,
  input wire [7:0] writeData,
  input wire periphOe,
  output reg [7:0] padReg,
  output reg padOe,
  output reg inputEnableBit,
  output reg [1:0] driveSel,
  output reg pullUpEn,
  output reg pullDownEn,
  output reg schmittEn,
  output reg fastEdgeSel
);

  reg [7:0] padNext;

  always @* begin
    padNext = writeEn ? writeData : padReg;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      padReg <= RESET_VALUE;
      padOe <= 1'b0;
      inputEnableBit <= RESET_VALUE[`PCR_BIT_IE];
      driveSel <= RESET_VALUE[`PCR_DRV_HI:`PCR_DRV_LO];
      pullUpEn <= RESET_VALUE[`PCR_BIT_PU];
      pullDownEn <= RESET_VALUE[`PCR_BIT_PD];
      schmittEn <= RESET_VALUE[`PCR_BIT_SCH];
      fastEdgeSel <= RESET_VALUE[`PCR_BIT_FAST];
    end else begin
      padReg <= padNext;
      // Output disable wins over any peripheral enable.
      padOe <= periphOe & ~padNext[`PCR_BIT_OD]; // [RULE1]
      inputEnableBit <= padNext[`PCR_BIT_IE]; // [RULE6]
      driveSel <= padNext[`PCR_DRV_HI:`PCR_DRV_LO]; // [RULE2]
      pullUpEn <= padNext[`PCR_BIT_PU]; // [RULE6]
      pullDownEn <= padNext[`PCR_BIT_PD]; // [RULE6]
      schmittEn <= padNext[`PCR_BIT_SCH]; // [RULE6]
      fastEdgeSel <= padNext[`PCR_BIT_FAST]; // [RULE4]
    end
  end

endmodule // pcr_pad_ctrl

`default_nettype wire

// file: verification/pcr_pad_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_pad_regs_sva (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [6:0] periphOe,
  input wire [6:0] padOe,
  input wire [13:0] driveSel,
  input wire [6:0] fastEdgeSel,
  input wire voltageSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire mapped = (paddr <= 12'h018 && paddr[1:0] == 2'h0) || paddr == 12'h080;
  sequence sTaken; psel && penable && !pready; endsequence
  sequence sRead; pready && !pwrite; endsequence
  AST_RDY: assert property (sTaken |=> pready ##1 !pready)
    else $error("ready is not a single pulse");
  AST_ERR: assert property (sTaken ##1 pready |-> pslverr == !mapped)
    else $error("error flag does not match decode");
  AST_OE: assert property ((padOe & ~$past(periphOe)) == 7'h00)
    else $error("pad driven without request");
  AST_RSV: assert property (sRead |-> prdata[31:8] == 24'h000000)
    else $error("reserved bits read nonzero");
  AST_VRD: assert property ((sRead and (paddr == 12'h000)) |-> prdata == {31'h0, voltageSel})
    else $error("voltage readback differs");
  AST_VRST: assert property ($rose(reset_n) |-> !voltageSel)
    else $error("voltage not low after reset");
  AST_HOLD: assert property ($changed(driveSel) || $changed(fastEdgeSel) |-> $past(psel && penable && pwrite))
    else $error("pad field changed without write");
endmodule // pcr_pad_regs_sva
bind pcr_pad_regs pcr_pad_regs_sva u_sva (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .periphOe, .padOe, .driveSel, .fastEdgeSel, .voltageSel);
`default_nettype wire

// file: verification/tb_pcr_pad_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcr_pad_regs;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h359C;
  logic [3:0] pstrb = 4'hF;
  logic [6:0] periphOe = 7'h7F, padOe, inputEnableBit, pullUpEn, pullDownEn, schmittEn, fastEdgeSel;
  logic [13:0] driveSel;
  logic pready, pslverr, voltageSel, err;
  logic [31:0] expVal [8] = '{32'h0, 32'h56, 32'h52, 32'h52, 32'h52, 32'h52, 32'h5A, 32'h5A};
  int n_fail = 0, n_tests = 0, i, k;
  pcr_pad_regs dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .periphOe, .padOe, .inputEnableBit, .driveSel, .pullUpEn, .pullDownEn,
    .schmittEn, .fastEdgeSel, .voltageSel);
  initial forever #4 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [11:0] adr(input int n);
    return n == 7 ? 12'h080 : 12'(n * 4);
  endfunction
  task automatic print_verdict();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // Request is held from setup until the edge where ready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    t = 0;
    do begin @(posedge clk); t++; end while (pready !== 1'b1 && t < 20);
    if (t == 20) begin n_fail++; print_verdict(); end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdchk(input int n);
    int p;
    p = n - 1;
    apb(0, adr(n), 32'h0);
    chk("readback", expVal[n], rd);
    if (n == 0) chk("vsel", expVal[0], {31'h0, voltageSel});
    else begin
      chk("fields", expVal[n][6:0], {inputEnableBit[p], driveSel[2*p+:2], pullUpEn[p], pullDownEn[p], schmittEn[p], fastEdgeSel[p]});
      chk("padoe", periphOe[p] & ~expVal[n][7], padOe[p]);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1;
    for (i = 0; i < 8; i++) rdchk(i);
    for (k = 0; k < 4; k++) begin
      apb(1, 12'h004, 32'h81 | (k << 4));
      expVal[1] = 32'h81 | (k << 4);
      rdchk(1);
    end
    apb(1, 12'h000, 32'hFFFFFFFF);
    expVal[0] = 32'h1;
    rdchk(0);
    pstrb <= 4'h0;
    apb(1, 12'h008, 32'hFF);
    pstrb <= 4'hF;
    rdchk(2);
    apb(0, 12'h01C, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1, 12'h07C, 32'hFF);
    chk("wrerr", 32'h1, {31'h0, err});
    rdchk(7);
    for (k = 0; k < 40; k++) begin
      lfsr = nxt(lfsr);
      i = lfsr[2:0];
      periphOe <= lfsr[14:8];
      lfsr = nxt(lfsr);
      apb(1, adr(i), lfsr);
      expVal[i] = lfsr & (i != 0 ? 32'hFF : 32'h1);
      rdchk(i);
    end
    print_verdict();
  end
endmodule // tb_pcr_pad_regs
`default_nettype wire
